// *** core/acs_serial_slave.v ***
// configuration serial slave: instruction decode, register space, pin direction
//
// Contract
// - any slow serial clock works, including pauses between edges.
// - three-wire by default; config bit 7 enables dedicated output pin.
// - slave only, half duplex; data pin direction follows protocol phase.
// - four-wire mode drives dedicated output even while deselected.
// - instruction capture starts on first rising clock after select falls.
// - MSB first by default; config bit 6 selects LSB first.
// - address steps up in MSB-first mode, down in LSB-first mode.
// - instruction: read flag on top, two length bits, 13-bit address.
// - length code 00/01/10 gives 1/2/3 bytes, 11 streams.
// - data bytes follow instruction while selected and clock toggles.
// - short transfers may stall select at any byte boundary.
// - streams stall only before first data byte; later rise aborts.
// - writing config bit 5 returns all registers to defaults.
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_serial_slave #(
    parameter AW = 8
) (
    // system
    input  wire          clk,
    input  wire          arst_n,
    input  wire          ce,
    // serial link pins
    input  wire          sclk,
    input  wire          chipSelectN,
    input  wire          sdioIn,
    output wire          sdioOut,
    output wire          sdioOe,
    output wire          serialDataOut,
    output wire          serialDataOutOe,
    // register write tap
    output reg           regWrStrobe,
    output reg  [AW-1:0] regWrAddr,
    output reg  [7:0]    regWrData,
    // register read tap
    input  wire [AW-1:0] rdAddr,
    output reg  [7:0]    rdData,
    // status
    output wire          cfgFourWire,
    output wire          cfgLsbFirst,
    output wire          xferActive
);

    localparam NREG = 1 << AW;

    localparam [2:0] ST_INSTR = 3'b001;
    localparam [2:0] ST_DATA  = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    // bit of a byte in the selected order
    function pickBit;
        input [7:0] b;
        input [2:0] i;
        input       lsb;
        begin
            pickBit = lsb ? b[i] : b[3'd7 - i];
        end
    endfunction

    // next register address of a multi-byte transfer
    function [12:0] stepAddr;
        input [12:0] a;
        input        lsb;
        begin
            stepAddr = lsb ? a - 13'h0001 : a + 13'h0001;
        end
    endfunction

    wire [2:0]  syncQ;
    wire        sclkS;
    wire        csNS;
    wire        sdS;

    reg         sclkD_r;
    reg  [2:0]  state_r;
    reg  [3:0]  bitCnt_r;
    reg  [15:0] shift_r;
    reg         rw_r;
    reg  [1:0]  len_r;
    reg  [12:0] addr_r;
    reg  [1:0]  dataCnt_r;
    reg  [7:0]  outByte_r;
    reg         sdo_r;
    reg  [7:0]  regs [0:NREG-1];

    wire        selected;
    wire        rise;
    wire        fall;
    wire        inInstr;
    wire        inData;
    wire        lsbFirst;
    wire [15:0] insNxt;
    wire [7:0]  datNxt;
    wire [12:0] addrStep_nxt;
    wire [12:0] insAddr;
    wire        insDone;
    wire        byteDone;
    wire        wrEn;
    wire        softRst;
    wire        midByte;
    wire        streamBusy;
    wire        abort;
    wire        lastByte;

    // every pin passes two flops; no lower bound on link rate
    acs_sync #(
        .W (3)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .d      ({sclk, chipSelectN, sdioIn}),
        .q      (syncQ)
    );

    assign sclkS = syncQ[2];
    assign csNS  = syncQ[1];
    assign sdS   = syncQ[0];

    // edges found by sampling; a paused clock simply yields no edge
    // reset low matches the idle clock level, so no false edge follows reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkD_r <= 1'b0;
        end else if (ce) begin
            sclkD_r <= sclkS;
        end
    end

    assign selected = ~csNS;
    assign rise     = ce & selected & sclkS & ~sclkD_r;
    assign fall     = ce & selected & ~sclkS & sclkD_r;

    assign inInstr  = state_r == ST_INSTR;
    assign inData   = state_r == ST_DATA;

    assign cfgFourWire = regs[`ACS_CFG_ADDR][`ACS_CFG_SDO_BIT];
    assign cfgLsbFirst = regs[`ACS_CFG_ADDR][`ACS_CFG_LSB_BIT];
    assign lsbFirst    = cfgLsbFirst;

    // whole word and each byte shift in the configured order
    assign insNxt = lsbFirst ? {sdS, shift_r[15:1]} : {shift_r[14:0], sdS};
    assign datNxt = lsbFirst ? {sdS, shift_r[7:1]} : {shift_r[6:0], sdS};

    // field split of the received instruction
    assign insAddr = insNxt[`ACS_INS_ADDR_HI:0];
    assign insDone = rise & inInstr & (bitCnt_r == `ACS_INS_LAST);

    assign byteDone = rise & inData & (bitCnt_r == `ACS_BYTE_LAST);
    assign wrEn     = byteDone & ~rw_r;
    // soft reset beats the ordinary write of the same byte
    assign softRst  = wrEn & (addr_r[AW-1:0] == `ACS_CFG_ADDR)
                      & datNxt[`ACS_CFG_SRST_BIT];

    // up in MSB-first mode, down in LSB-first mode
    assign addrStep_nxt = stepAddr(addr_r, lsbFirst);

    // fixed lengths end after len+1 data bytes; stream code never ends
    assign lastByte = (len_r != `ACS_LEN_STREAM) && (dataCnt_r == len_r);

    // a stall is tolerated only on a byte boundary
    assign midByte    = bitCnt_r[2:0] != 3'h0;
    // stream already past its first data byte
    assign streamBusy = inData & (len_r == `ACS_LEN_STREAM)
                        & (dataCnt_r != 2'b00);
    // bits shifted before a mid-byte cut have no owner, so such a cut restarts
    assign abort      = midByte | streamBusy | (state_r == ST_DONE);

    // protocol engine
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r   <= ST_INSTR;
            bitCnt_r  <= 4'h0;
            shift_r   <= 16'h0000;
            rw_r      <= 1'b0;
            len_r     <= `ACS_LEN_ONE;
            addr_r    <= 13'h0000;
            dataCnt_r <= 2'b00;
            outByte_r <= 8'h00;
        end else if (ce) begin
            if (!selected) begin
                // deselect either stalls in place or restarts
                if (abort) begin
                    state_r   <= ST_INSTR;
                    bitCnt_r  <= 4'h0;
                    dataCnt_r <= 2'b00;
                end
            end else if (rise) begin
                case (state_r)
                    ST_INSTR: begin
                        // first rising edge after select falls starts the word
                        shift_r <= insNxt;
                        if (insDone) begin
                            rw_r      <= insNxt[`ACS_INS_RW_BIT];
                            len_r     <= insNxt[`ACS_INS_LEN_HI:`ACS_INS_LEN_LO];
                            addr_r    <= insAddr;
                            outByte_r <= regs[insAddr[AW-1:0]];
                            dataCnt_r <= 2'b00;
                            bitCnt_r  <= 4'h0;
                            state_r   <= ST_DATA;
                        end else begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                    ST_DATA: begin
                        shift_r <= {8'h00, datNxt};
                        if (bitCnt_r == `ACS_BYTE_LAST) begin
                            bitCnt_r  <= 4'h0;
                            addr_r    <= addrStep_nxt;
                            // prefetched at the boundary; a later write to it is not seen
                            outByte_r <= regs[addrStep_nxt[AW-1:0]];
                            // saturates so a long stream never wraps back to zero, where a deselect would stall instead of abort
                            if (dataCnt_r != 2'b11) begin
                                dataCnt_r <= dataCnt_r + 2'b01;
                            end
                            if (lastByte) begin
                                state_r <= ST_DONE;
                            end
                        end else begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end
                    end
                    ST_DONE: begin
                        // surplus clocks are ignored until deselect
                        state_r <= ST_DONE;
                    end
                    default: begin
                        state_r  <= ST_INSTR;
                        bitCnt_r <= 4'h0;
                    end
                endcase
            end
        end
    end

    // read data moves on falling edges so the master samples on rising
    // fall already carries ce, so a frozen clock holds the bit
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_r <= 1'b0;
        end else if (fall && inData && rw_r) begin
            sdo_r <= pickBit(outByte_r, bitCnt_r[2:0], lsbFirst);
        end
    end

    // register space; soft reset restores every default
    integer i;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < NREG; i = i + 1) begin
                regs[i] <= (i == 0) ? `ACS_CFG_RST : `ACS_REG_RST;
            end
        end else if (ce) begin
            if (softRst) begin
                for (i = 0; i < NREG; i = i + 1) begin
                    regs[i] <= (i == 0) ? `ACS_CFG_RST : `ACS_REG_RST;
                end
            end else if (wrEn) begin
                regs[addr_r[AW-1:0]] <= datNxt;
            end
        end
    end

    // taps toward the rest of the converter
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regWrStrobe <= 1'b0;
            regWrAddr   <= {AW{1'b0}};
            regWrData   <= 8'h00;
            rdData      <= 8'h00;
        end else if (ce) begin
            regWrStrobe <= wrEn;
            if (wrEn) begin
                regWrAddr <= addr_r[AW-1:0];
                regWrData <= datNxt;
            end
            rdData <= regs[rdAddr];
        end
    end

    // pin drive: slave never starts anything, it only answers reads
    // three-wire: data pin turns round only during read data
    assign sdioOe  = ~cfgFourWire & selected & inData & rw_r;
    assign sdioOut = sdo_r;

    // four-wire output is driven whether selected or not
    assign serialDataOut   = sdo_r;
    // limitation: four-wire parts cannot share one output line
    assign serialDataOutOe = cfgFourWire;

    assign xferActive = inData | (inInstr & (bitCnt_r != 4'h0));

endmodule // acs_serial_slave

// *** core/acs_map.vh ***
// constants for the converter configuration serial slave
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// configuration register location and field positions
`define ACS_CFG_ADDR      8'h00
`define ACS_CFG_SDO_BIT   7
`define ACS_CFG_LSB_BIT   6
`define ACS_CFG_SRST_BIT  5

// reset values
`define ACS_CFG_RST       8'h18
`define ACS_REG_RST       8'h00

// instruction word layout
`define ACS_INS_RW_BIT    15
`define ACS_INS_LEN_HI    14
`define ACS_INS_LEN_LO    13
`define ACS_INS_ADDR_HI   12
`define ACS_INS_BITS      16

// transfer length codes
`define ACS_LEN_ONE       2'b00
`define ACS_LEN_TWO       2'b01
`define ACS_LEN_THREE     2'b10
`define ACS_LEN_STREAM    2'b11

// bit counts
`define ACS_INS_LAST      4'h0F
`define ACS_BYTE_LAST     4'h07

`endif

// *** core/acs_sync.v ***
// two-flop synchroniser for pin inputs, frozen by clock enable
`timescale 1ns/100ps
module acs_sync #(
    parameter W = 1
) (
    // system
    input  wire         clk,
    input  wire         arst_n,
    input  wire         ce,
    // data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // first stage feeds only the second stage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else if (ce) begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule // acs_sync

// *** verif/acs_slave_monitor.sv ***
// assertions on the serial slave ports
`timescale 1ns/100ps
module acs_slave_monitor #(
    parameter AW = 8
) (
    // system
    input wire          clk,
    input wire          arst_n,
    // link
    input wire          sclk,
    input wire          chipSelectN,
    input wire          sdioOut,
    input wire          sdioOe,
    input wire          serialDataOutOe,
    // taps
    input wire          regWrStrobe,
    input wire [AW-1:0] regWrAddr,
    input wire [7:0]    regWrData,
    input wire          cfgFourWire,
    input wire          cfgLsbFirst,
    input wire          xferActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_sdo_enable: assert property (serialDataOutOe == cfgFourWire)
        else $error("sdo enable wrong");
    a_sdio_turn: assert property (sdioOe |-> xferActive && !cfgFourWire)
        else $error("sdio driven out of phase");
    a_idle_release: assert property (chipSelectN [*4] |-> !sdioOe)
        else $error("sdio driven while deselected");
    a_read_hold: assert property (sclk [*3] |-> $stable(sdioOut))
        else $error("read bit moved while clock high");
    a_strobe_pulse: assert property (regWrStrobe |=> !regWrStrobe)
        else $error("write strobe too long");
    a_strobe_framed: assert property (regWrStrobe |-> $past(xferActive))
        else $error("write outside data phase");
    a_cfg_write: assert property (regWrStrobe && regWrAddr == 0 && !regWrData[5]
        |-> ##[0:1] cfgFourWire == regWrData[7] && cfgLsbFirst == regWrData[6])
        else $error("mode bits not taken");
    a_soft_reset: assert property (regWrStrobe && regWrAddr == 0 && regWrData[5]
        |-> ##[0:1] !cfgFourWire && !cfgLsbFirst)
        else $error("soft reset missed");
    c_write: cover property (regWrStrobe);
    c_read: cover property ($rose(sdioOe));
    c_four: cover property ($rose(serialDataOutOe));
endmodule // acs_slave_monitor

// *** verif/acs_host_model.sv ***
// host serial master model
`timescale 1ns/100ps
module acs_host_model (
    // system
    input  wire clk,
    // link
    output reg  sclk,
    output reg  chipSelectN,
    output wire sdioIn,
    input  wire sdioOut,
    input  wire sdioOe,
    input  wire serialDataOut,
    input  wire serialDataOutOe
);
    reg drv;
    int hp = 4; // 160 ns clock, inside the sampling limit; there is no lower limit
    assign sdioIn = sdioOe ? sdioOut : drv;
    initial {sclk, chipSelectN, drv} = 3'b010;
    task automatic half();
        repeat (hp) @(negedge clk);
    endtask
    // stallAt: bit count where select pauses, 0 for none
    task automatic frame(input logic [15:0] ins, input int nBits, input int stallAt,
                         input logic lsb, input logic [31:0] wd, output logic [31:0] rd);
        int i;
        int k;
        rd = 32'h0000_0000;
        half(); // clock static low first
        chipSelectN = 1'b0;
        for (i = 0; i < nBits; i++) begin
            k = (i / 8 - 2) * 8 + (lsb ? i % 8 : 7 - i % 8);
            if (stallAt != 0 && i == stallAt) begin
                chipSelectN = 1'b1;
                repeat (3) half();
                chipSelectN = 1'b0;
            end
            if (i < 16)
                drv = ins[lsb ? i : 15 - i];
            else if (ins[15])
                drv = ~drv; // released line toggles, never holds the last bit
            else
                drv = wd[k];
            half();
            sclk = 1'b1;
            half();
            if (i >= 16)
                rd[k] = serialDataOutOe ? serialDataOut : sdioIn;
            sclk = 1'b0;
        end
        half();
        chipSelectN = 1'b1;
        repeat (2) half();
    endtask
endmodule // acs_host_model

// *** verif/tb.sv ***
// self-checking bench for the serial slave
`timescale 1ns/100ps
module tb;
    logic        clk, arst_n, ce, sclk, chipSelectN, sdioIn, sdioOut, sdioOe, serialDataOut;
    logic        serialDataOutOe, regWrStrobe, cfgFourWire, cfgLsbFirst, xferActive, lsbMode;
    logic [7:0]  regWrAddr, regWrData, rdAddr, rdData;
    logic [31:0] got;
    int          n_mismatch = 0, checks_done = 0, cycles = 0;
    acs_serial_slave #(.AW(8)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .sclk(sclk), .chipSelectN(chipSelectN),
        .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialDataOut(serialDataOut),
        .serialDataOutOe(serialDataOutOe), .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .rdAddr(rdAddr), .rdData(rdData), .cfgFourWire(cfgFourWire),
        .cfgLsbFirst(cfgLsbFirst), .xferActive(xferActive));
    acs_host_model host ( // sole slave on the link, so reads never collide
        .clk(clk), .sclk(sclk), .chipSelectN(chipSelectN), .sdioIn(sdioIn), .sdioOut(sdioOut),
        .sdioOe(sdioOe), .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic rw, input logic [1:0] code, input logic [7:0] a,
                        input int nBits, input int stall, input logic [31:0] wd);
        // stimulus touches only the config register and plain data locations
        host.frame({rw, code, 5'h00, a}, nBits, stall, lsbMode, wd, got);
    endtask
    task automatic regIs(input logic [7:0] a, input logic [7:0] exp);
        rdAddr = a;
        @(negedge clk);
        chk("register", {24'h00_0000, rdData}, {24'h00_0000, exp});
    endtask
    task automatic tBasic();
        regIs(8'h00, 8'h18);
        chk("lsbFirst", cfgLsbFirst, 1'b0);
        xfer(1'b0, 2'b00, 8'h05, 24, 0, 32'h0000_00A5);
        regIs(8'h05, 8'hA5);
        chk("wrAddr", regWrAddr, 8'h05);
        chk("wrData", regWrData, 8'hA5);
        chk("xferActive", xferActive, 1'b0);
        xfer(1'b1, 2'b00, 8'h05, 24, 0, 32'h0000_0000);
        chk("readByte", got[7:0], 8'hA5);
    endtask
    task automatic tLengths();
        int c;
        int k;
        for (c = 0; c < 4; c++) begin
            // one byte past the coded length must be ignored
            xfer(1'b0, c[1:0], 8'h10 + 8'(c * 8), 16 + 8 * ((c < 3) ? c + 2 : 4), 0,
                 32'h4433_2211);
            for (k = 0; k < 4; k++)
                regIs(8'h10 + 8'(c * 8 + k),
                      (k <= c || c == 3) ? 8'(17 * (k + 1)) : 8'h00);
        end
    endtask
    task automatic tStall();
        xfer(1'b0, 2'b01, 8'h50, 32, 24, 32'h0000_6655);
        regIs(8'h51, 8'h66);
        xfer(1'b0, 2'b11, 8'h58, 32, 8, 32'h0000_7766);
        regIs(8'h59, 8'h77);
        // pause after first stream byte, then a byte plus a half byte
        xfer(1'b0, 2'b11, 8'h60, 36, 24, 32'h0000_9988);
        regIs(8'h60, 8'h88);
        regIs(8'h61, 8'h00);
    endtask
    task automatic tSlow();
        host.hp = 40;
        xfer(1'b0, 2'b00, 8'h07, 24, 0, 32'h0000_003C);
        host.hp = 4;
        regIs(8'h07, 8'h3C);
        // a frame sent while the block is frozen must leave no trace
        ce = 1'b0;
        xfer(1'b0, 2'b00, 8'h08, 24, 0, 32'h0000_0077);
        ce = 1'b1;
        regIs(8'h08, 8'h00);
    endtask
    task automatic tModes();
        xfer(1'b0, 2'b00, 8'h00, 24, 0, 32'h0000_005A); // mirrored nibbles
        lsbMode = 1'b1;
        xfer(1'b0, 2'b01, 8'h41, 32, 0, 32'h0000_C3B2);
        regIs(8'h40, 8'hC3);
        xfer(1'b1, 2'b01, 8'h41, 32, 0, 32'h0000_0000);
        chk("readPair", got[15:0], 16'hC3B2);
        xfer(1'b0, 2'b00, 8'h00, 24, 0, 32'h0000_0099);
        chk("fourWire", cfgFourWire, 1'b1);
        lsbMode = 1'b0;
        xfer(1'b1, 2'b00, 8'h05, 24, 0, 32'h0000_0000);
        chk("readSdo", got[7:0], 8'hA5);
        xfer(1'b0, 2'b00, 8'h00, 24, 0, 32'h0000_003C);
        regIs(8'h05, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        rdAddr = 8'h00;
        lsbMode = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        tBasic();
        tLengths();
        tStall();
        tSlow();
        tModes();
        conclude();
    end
endmodule // tb
bind acs_serial_slave acs_slave_monitor #(.AW(AW)) mon (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .chipSelectN(chipSelectN), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .serialDataOutOe(serialDataOutOe), .regWrStrobe(regWrStrobe),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .cfgFourWire(cfgFourWire),
    .cfgLsbFirst(cfgLsbFirst), .xferActive(xferActive));
